// file: rtl/gpc_pkg.sv
// constants, types and register map for the port C/D/E pin logic
// assumes one 20 MHz system clock and a word-wide register port
`default_nettype none

package gpc_pkg;

  // ==========================================================
  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned PC_W = 15;
  localparam int unsigned PD_W = 9;
  localparam int unsigned PE_W = 14;

  // ==========================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] PC_DIR_ADDR = 32'hB800_3004;
  localparam logic [ADDR_W-1:0] PC_DRV_ADDR = 32'hB800_3008;
  localparam logic [ADDR_W-1:0] PC_LVL_ADDR = 32'hB800_300C;
  localparam logic [ADDR_W-1:0] PD_DIR_ADDR = 32'hB800_3014;
  localparam logic [ADDR_W-1:0] PD_DRV_ADDR = 32'hB800_3018;
  localparam logic [ADDR_W-1:0] PD_LVL_ADDR = 32'hB800_301C;
  localparam logic [ADDR_W-1:0] PE_DIR_ADDR = 32'hB800_3024;

  // ==========================================================
  // implemented bit masks
  localparam logic [PC_W-1:0] PC_MASK = 15'h7FFF;
  localparam logic [PD_W-1:0] PD_MASK = 9'h17F;
  localparam logic [PE_W-1:0] PE_MASK = 14'h20CF;

  // ==========================================================
  // values after reset
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PD_W-1:0] PD_RST = 9'h000;
  localparam logic [PE_W-1:0] PE_RST = 14'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================
  // read selection
  typedef enum logic [2:0] {
    GPC_RS_NONE   = 3'h0,
    GPC_RS_PC_DIR = 3'h1,
    GPC_RS_PC_DRV = 3'h2,
    GPC_RS_PC_LVL = 3'h3,
    GPC_RS_PD_DIR = 3'h4,
    GPC_RS_PD_DRV = 3'h5,
    GPC_RS_PD_LVL = 3'h6,
    GPC_RS_PE_DIR = 3'h7
  } gpc_rsel_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gpc_bus_req_t;

  typedef struct packed {
    logic [PC_W-1:0] oe;
    logic [PC_W-1:0] val;
  } gpc_pc_drv_t;

  typedef struct packed {
    logic [PD_W-1:0] oe;
    logic [PD_W-1:0] val;
  } gpc_pd_drv_t;

  typedef struct packed {
    logic [PE_W-1:0] oe;
    logic [PE_W-1:0] val;
  } gpc_pe_drv_t;

endpackage

`default_nettype wire

// file: rtl/gpc_sync.sv
// two-flop level synchroniser for a bundle of pin inputs
// assumes each bit is an independent level
`default_nettype none

module gpc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // asynchronous levels
  input wire logic [W-1:0] i_d,
  // synchronised levels
  output var logic [W-1:0] o_q
);

  // ==========================================================
  // stages
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule

`default_nettype wire

// file: rtl/gpc_field_reg.sv
// one software-writable field with a reset value
// assumes write data arrive already masked to implemented bits
`default_nettype none

module gpc_field_reg #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // write side
  input wire logic i_we,
  input wire logic [W-1:0] i_wdata,
  // stored value
  output var logic [W-1:0] o_q
);

  // ==========================================================
  // storage
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  assign q_nxt = i_we ? i_wdata : q_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      q_r <= RST;
    else
      q_r <= q_nxt;
  end

  assign o_q = q_r;

endmodule

`default_nettype wire

// file: rtl/gpc_ports.sv
// pin logic and registers for general-purpose ports C, D and E
// assumes a one-cycle register port and pins synchronous-safe via sync
//
// Operation
// - port C level bits 14..0 show each pin level in any direction
// - reserved level bits read zero
// - port D direction bits 8..0, 1 drives; bit 7 inert
// - port D drive value reaches pins set to output; bit 7 inert
// - writes to reserved drive bits change nothing
// - port D level bits 8..0 show pin levels; bit 7 reads zero
// - port E direction bits 13..0; bits 12..8 and 5..4 inert
// - port D and E directions reset to zero, all pins inputs
// - port D drive value is read/write and resets to zero
// - level registers are read-only; writes ignored
// - port C direction bits 14..0, resets to zero
// - port C drive value bits 14..0 reach output pins, reset zero
`default_nettype none

module gpc_ports (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire gpc_pkg::gpc_bus_req_t i_bus,
  output var logic [gpc_pkg::DATA_W-1:0] o_rdata,
  // port C pins
  input wire logic [gpc_pkg::PC_W-1:0] i_pc_pin,
  output var gpc_pkg::gpc_pc_drv_t o_pc,
  // port D pins
  input wire logic [gpc_pkg::PD_W-1:0] i_pd_pin,
  output var gpc_pkg::gpc_pd_drv_t o_pd,
  // port E pins
  input wire logic [gpc_pkg::PE_W-1:0] i_pe_drive,
  output var gpc_pkg::gpc_pe_drv_t o_pe
);

  // ==========================================================
  // address match
  function automatic logic addr_hit(
    input logic [gpc_pkg::ADDR_W-1:0] a,
    input logic [gpc_pkg::ADDR_W-1:0] r
  );
    addr_hit = (a == r);
  endfunction

  // ==========================================================
  // declarations
  logic hit_pc_dir;
  logic hit_pc_drv;
  logic hit_pc_lvl;
  logic hit_pd_dir;
  logic hit_pd_drv;
  logic hit_pd_lvl;
  logic hit_pe_dir;

  logic we_pc_dir;
  logic we_pc_drv;
  logic we_pd_dir;
  logic we_pd_drv;
  logic we_pe_dir;

  logic [gpc_pkg::PC_W-1:0] wd_pc;
  logic [gpc_pkg::PD_W-1:0] wd_pd;
  logic [gpc_pkg::PE_W-1:0] wd_pe;

  logic [gpc_pkg::PC_W-1:0] pc_dir_q;
  logic [gpc_pkg::PC_W-1:0] pc_drv_q;
  logic [gpc_pkg::PD_W-1:0] pd_dir_q;
  logic [gpc_pkg::PD_W-1:0] pd_drv_q;
  logic [gpc_pkg::PE_W-1:0] pe_dir_q;

  logic [gpc_pkg::PC_W-1:0] pc_lvl;
  logic [gpc_pkg::PD_W-1:0] pd_lvl;

  logic [gpc_pkg::PE_W-1:0] pe_val_r;
  logic [gpc_pkg::PE_W-1:0] pe_val_nxt;

  gpc_pkg::gpc_rsel_t rd_sel;

  logic [gpc_pkg::DATA_W-1:0] rb_pc_dir;
  logic [gpc_pkg::DATA_W-1:0] rb_pc_drv;
  logic [gpc_pkg::DATA_W-1:0] rb_pc_lvl;
  logic [gpc_pkg::DATA_W-1:0] rb_pd_dir;
  logic [gpc_pkg::DATA_W-1:0] rb_pd_drv;
  logic [gpc_pkg::DATA_W-1:0] rb_pd_lvl;
  logic [gpc_pkg::DATA_W-1:0] rb_pe_dir;
  logic [gpc_pkg::DATA_W-1:0] rb_sel;

  logic [gpc_pkg::DATA_W-1:0] rdata_r;
  logic [gpc_pkg::DATA_W-1:0] rdata_nxt;

  // ==========================================================
  // address decode
  assign hit_pc_dir = addr_hit(i_bus.addr, gpc_pkg::PC_DIR_ADDR);
  assign hit_pc_drv = addr_hit(i_bus.addr, gpc_pkg::PC_DRV_ADDR);
  assign hit_pc_lvl = addr_hit(i_bus.addr, gpc_pkg::PC_LVL_ADDR);
  assign hit_pd_dir = addr_hit(i_bus.addr, gpc_pkg::PD_DIR_ADDR);
  assign hit_pd_drv = addr_hit(i_bus.addr, gpc_pkg::PD_DRV_ADDR);
  assign hit_pd_lvl = addr_hit(i_bus.addr, gpc_pkg::PD_LVL_ADDR);
  assign hit_pe_dir = addr_hit(i_bus.addr, gpc_pkg::PE_DIR_ADDR);

  // ==========================================================
  // write enables, level addresses take none
  assign we_pc_dir = i_bus.wr & hit_pc_dir;
  assign we_pc_drv = i_bus.wr & hit_pc_drv;
  assign we_pd_dir = i_bus.wr & hit_pd_dir;
  assign we_pd_drv = i_bus.wr & hit_pd_drv;
  assign we_pe_dir = i_bus.wr & hit_pe_dir;

  // ==========================================================
  // write data cut to implemented bits
  assign wd_pc = i_bus.wdata[gpc_pkg::PC_W-1:0] & gpc_pkg::PC_MASK;
  assign wd_pd = i_bus.wdata[gpc_pkg::PD_W-1:0] & gpc_pkg::PD_MASK;
  assign wd_pe = i_bus.wdata[gpc_pkg::PE_W-1:0] & gpc_pkg::PE_MASK;

  // ==========================================================
  // port C direction
  gpc_field_reg #(
    .W(gpc_pkg::PC_W),
    .RST(gpc_pkg::PC_RST)
  ) u_pc_dir (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(we_pc_dir),
    .i_wdata(wd_pc),
    .o_q(pc_dir_q)
  );

  // ==========================================================
  // port C drive value
  gpc_field_reg #(
    .W(gpc_pkg::PC_W),
    .RST(gpc_pkg::PC_RST)
  ) u_pc_drv (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(we_pc_drv),
    .i_wdata(wd_pc),
    .o_q(pc_drv_q)
  );

  // ==========================================================
  // port D direction
  gpc_field_reg #(
    .W(gpc_pkg::PD_W),
    .RST(gpc_pkg::PD_RST)
  ) u_pd_dir (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(we_pd_dir),
    .i_wdata(wd_pd),
    .o_q(pd_dir_q)
  );

  // ==========================================================
  // port D drive value
  gpc_field_reg #(
    .W(gpc_pkg::PD_W),
    .RST(gpc_pkg::PD_RST)
  ) u_pd_drv (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(we_pd_drv),
    .i_wdata(wd_pd),
    .o_q(pd_drv_q)
  );

  // ==========================================================
  // port E direction
  gpc_field_reg #(
    .W(gpc_pkg::PE_W),
    .RST(gpc_pkg::PE_RST)
  ) u_pe_dir (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(we_pe_dir),
    .i_wdata(wd_pe),
    .o_q(pe_dir_q)
  );

  // ==========================================================
  // pin level synchronisers
  gpc_sync #(
    .W(gpc_pkg::PC_W)
  ) u_pc_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_pc_pin),
    .o_q(pc_lvl)
  );

  gpc_sync #(
    .W(gpc_pkg::PD_W)
  ) u_pd_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_pd_pin),
    .o_q(pd_lvl)
  );

  // ==========================================================
  // port E drive value registered from the i_pe_drive input
  assign pe_val_nxt = i_pe_drive & gpc_pkg::PE_MASK;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      pe_val_r <= gpc_pkg::PE_RST;
    else
      pe_val_r <= pe_val_nxt;
  end

  // ==========================================================
  // readback words, upper bits zero
  assign rb_pc_dir = 32'(pc_dir_q);
  assign rb_pc_drv = 32'(pc_drv_q);
  assign rb_pc_lvl = 32'(pc_lvl);
  assign rb_pd_dir = 32'(pd_dir_q);
  assign rb_pd_drv = 32'(pd_drv_q);
  assign rb_pd_lvl = 32'(pd_lvl & gpc_pkg::PD_MASK);
  assign rb_pe_dir = 32'(pe_dir_q);

  // ==========================================================
  // read select
  assign rd_sel =
    hit_pc_dir ? gpc_pkg::GPC_RS_PC_DIR :
    hit_pc_drv ? gpc_pkg::GPC_RS_PC_DRV :
    hit_pc_lvl ? gpc_pkg::GPC_RS_PC_LVL :
    hit_pd_dir ? gpc_pkg::GPC_RS_PD_DIR :
    hit_pd_drv ? gpc_pkg::GPC_RS_PD_DRV :
    hit_pd_lvl ? gpc_pkg::GPC_RS_PD_LVL :
    hit_pe_dir ? gpc_pkg::GPC_RS_PE_DIR :
    gpc_pkg::GPC_RS_NONE;

  // ==========================================================
  // read mux, unmapped reads zero
  always_comb
  begin
    rb_sel = gpc_pkg::RDATA_RST;
    unique case (rd_sel)
      gpc_pkg::GPC_RS_NONE:
        rb_sel = gpc_pkg::RDATA_RST;
      gpc_pkg::GPC_RS_PC_DIR:
        rb_sel = rb_pc_dir;
      gpc_pkg::GPC_RS_PC_DRV:
        rb_sel = rb_pc_drv;
      gpc_pkg::GPC_RS_PC_LVL:
        rb_sel = rb_pc_lvl;
      gpc_pkg::GPC_RS_PD_DIR:
        rb_sel = rb_pd_dir;
      gpc_pkg::GPC_RS_PD_DRV:
        rb_sel = rb_pd_drv;
      gpc_pkg::GPC_RS_PD_LVL:
        rb_sel = rb_pd_lvl;
      gpc_pkg::GPC_RS_PE_DIR:
        rb_sel = rb_pe_dir;
    endcase
  end

  assign rdata_nxt = i_bus.rd ? rb_sel : gpc_pkg::RDATA_RST;

  // ==========================================================
  // read data, valid one cycle after the strobe only
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      rdata_r <= gpc_pkg::RDATA_RST;
    else
      rdata_r <= rdata_nxt;
  end

  assign o_rdata = rdata_r;

  // ==========================================================
  // pin drive
  assign o_pc = '{
    oe: pc_dir_q,
    val: pc_drv_q
  };

  assign o_pd = '{
    oe: pd_dir_q,
    val: pd_drv_q
  };

  assign o_pe = '{
    oe: pe_dir_q,
    val: pe_val_r
  };

endmodule

`default_nettype wire

// file: rtl/README_none.sv
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// file: dv/gpc_ports_props.sv
// assertions on the port C/D/E pin logic
// assumes bind onto gpc_ports, one clock
`default_nettype none

module gpc_ports_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire gpc_pkg::gpc_bus_req_t i_bus,
  input wire logic [31:0] o_rdata,
  // pins
  input wire logic [14:0] i_pc_pin,
  input wire gpc_pkg::gpc_pc_drv_t o_pc,
  input wire gpc_pkg::gpc_pd_drv_t o_pd,
  input wire gpc_pkg::gpc_pe_drv_t o_pe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // decode
  wire logic [14:0] wd_pc;
  wire logic [8:0] wd_pd;
  wire logic [13:0] wd_pe;
  wire logic w_pd;
  wire logic r_pc;
  assign wd_pc = i_bus.wdata[14:0];
  assign wd_pd = i_bus.wdata[8:0];
  assign wd_pe = i_bus.wdata[13:0];
  assign w_pd = i_bus.wr && i_bus.addr == gpc_pkg::PD_DRV_ADDR;
  assign r_pc = i_bus.rd && i_bus.addr == gpc_pkg::PC_LVL_ADDR;
  // ==========================================
  // checks
  a_rdata_idle: assert property (
    !$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside a read slot");
  a_pd_dir_wr: assert property (
    i_bus.wr && i_bus.addr == gpc_pkg::PD_DIR_ADDR
    |=> o_pd.oe == ($past(wd_pd) & 9'h17F))
    else $error("port D direction write wrong");
  a_pd_drv_wr: assert property (
    w_pd |=> o_pd.val == ($past(wd_pd) & 9'h17F))
    else $error("port D drive write wrong");
  a_pd_drv_hold: assert property (
    !w_pd |=> $stable(o_pd.val))
    else $error("port D drive changed without write");
  a_pc_dir_wr: assert property (
    i_bus.wr && i_bus.addr == gpc_pkg::PC_DIR_ADDR
    |=> o_pc.oe == $past(wd_pc))
    else $error("port C direction write wrong");
  a_pc_drv_wr: assert property (
    i_bus.wr && i_bus.addr == gpc_pkg::PC_DRV_ADDR
    |=> o_pc.val == $past(wd_pc))
    else $error("port C drive write wrong");
  a_pe_dir_wr: assert property (
    i_bus.wr && i_bus.addr == gpc_pkg::PE_DIR_ADDR
    |=> o_pe.oe == ($past(wd_pe) & 14'h20CF))
    else $error("port E direction write wrong");
  a_pd_lvl_rsv: assert property (
    i_bus.rd && i_bus.addr == gpc_pkg::PD_LVL_ADDR
    |=> o_rdata[31:9] == 23'h0 && !o_rdata[7])
    else $error("port D level reserved bit set");
  a_pc_lvl_rsv: assert property (
    r_pc |=> o_rdata[31:15] == 17'h0)
    else $error("port C level reserved bit set");
  a_pc_level: assert property (
    r_pc && $past(i_rst_n) && $past(i_rst_n, 2) && $stable(i_pc_pin)
    && $past(i_pc_pin) == $past(i_pc_pin, 2)
    |=> o_rdata[14:0] == $past(i_pc_pin, 2))
    else $error("port C level readback wrong");
  c_pd_write: cover property (w_pd);
  c_pc_read: cover property (r_pc);
  c_pe_write: cover property (i_bus.wr && i_bus.addr == gpc_pkg::PE_DIR_ADDR);
endmodule

bind gpc_ports gpc_ports_props gpc_ports_props_i (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_bus(i_bus),
  .o_rdata(o_rdata),
  .i_pc_pin(i_pc_pin),
  .o_pc(o_pc),
  .o_pd(o_pd),
  .o_pe(o_pe)
);

`default_nettype wire

// file: dv/gpc_pin_model.sv
// pad model: level from module drive or board drive
// assumes the board drives every pin weakly, module wins
`default_nettype none

module gpc_pin_model (
  // module side
  input wire gpc_pkg::gpc_pc_drv_t i_pc,
  input wire gpc_pkg::gpc_pd_drv_t i_pd,
  // board side
  input wire logic [14:0] i_pc_ext,
  input wire logic [8:0] i_pd_ext,
  // pad levels
  output var logic [14:0] o_pc_pin,
  output var logic [8:0] o_pd_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // resolve pads
  assign o_pc_pin = (i_pc.oe & i_pc.val) | (~i_pc.oe & i_pc_ext);
  assign o_pd_pin = (i_pd.oe & i_pd.val) | (~i_pd.oe & i_pd_ext);
endmodule

`default_nettype wire

// file: dv/gpc_ports_bench.sv
// self-checking bench for the port C/D/E pin logic
// assumes the pad model and checker beside the design
`default_nettype none

module gpc_ports_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  gpc_pkg::gpc_bus_req_t bus = '0;
  logic [31:0] rdata;
  logic [14:0] pc_pin;
  logic [14:0] pc_ext = 15'h2AAA;
  logic [8:0] pd_pin;
  logic [8:0] pd_ext = 9'h0AA;
  logic [13:0] pe_drv = 14'h3FFF;
  gpc_pkg::gpc_pc_drv_t pc;
  gpc_pkg::gpc_pd_drv_t pd;
  gpc_pkg::gpc_pe_drv_t pe;
  logic [31:0] ra [5] = '{gpc_pkg::PC_DIR_ADDR, gpc_pkg::PC_DRV_ADDR,
    gpc_pkg::PD_DIR_ADDR, gpc_pkg::PD_DRV_ADDR, gpc_pkg::PE_DIR_ADDR};
  logic [31:0] rm [5] = '{32'h7FFF, 32'h7FFF, 32'h17F, 32'h17F, 32'h20CF};
  int errors = 0;
  int n_checks = 0;

  always #25 i_clk = ~i_clk;

  gpc_ports gpc_ports_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_pc_pin(pc_pin),
    .o_pc(pc),
    .i_pd_pin(pd_pin),
    .o_pd(pd),
    .i_pe_drive(pe_drv),
    .o_pe(pe)
  );

  gpc_pin_model gpc_pin_model_i (
    .i_pc(pc),
    .i_pd(pd),
    .i_pc_ext(pc_ext),
    .i_pd_ext(pd_ext),
    .o_pc_pin(pc_pin),
    .o_pd_pin(pd_pin)
  );

  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // tests
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], 32'h0);
    end
    $display("reset values done");
    for (int i = 0; i < 5; i++)
    begin
      wr(ra[i], 32'hFFFF_FFFF);
      rd(ra[i], rm[i]);
    end
    chk(32'(pd.oe), 32'h17F);
    chk(32'(pd.val), 32'h17F);
    chk(32'(pe.oe), 32'h20CF);
    chk(32'(pc.val), 32'h7FFF);
    chk(32'(pc.oe), 32'h7FFF);
    chk(32'(pe.val), 32'h20CF);
    wr(gpc_pkg::PD_DRV_ADDR, 32'hFFFF_FE80);
    rd(gpc_pkg::PD_DRV_ADDR, 32'h0);
    chk(32'(pd.val), 32'h0);
    $display("field masks done");
    wr(gpc_pkg::PC_DIR_ADDR, 32'h00FF);
    wr(gpc_pkg::PC_DRV_ADDR, 32'h5555);
    wr(gpc_pkg::PD_DIR_ADDR, 32'h1F0);
    wr(gpc_pkg::PD_DRV_ADDR, 32'h155);
    repeat (3) @(posedge i_clk);
    // driven bits from drive value, others from board
    rd(gpc_pkg::PC_LVL_ADDR, 32'h2A55);
    rd(gpc_pkg::PD_LVL_ADDR, 32'h15A);
    pc_ext <= 15'h5555;
    pd_ext <= 9'h155;
    repeat (3) @(posedge i_clk);
    rd(gpc_pkg::PC_LVL_ADDR, 32'h5555);
    rd(gpc_pkg::PD_LVL_ADDR, 32'h155);
    $display("pin levels done");
    wr(gpc_pkg::PD_LVL_ADDR, 32'h0);
    rd(gpc_pkg::PD_LVL_ADDR, 32'h155);
    wr(32'hB800_3010, 32'hFFFF_FFFF);
    rd(32'hB800_3010, 32'h0);
    rd(gpc_pkg::PD_DIR_ADDR, 32'h170);
    $display("read-only done");
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(gpc_pkg::PD_DRV_ADDR, 32'h0);
    chk(32'(pd.oe), 32'h0);
    chk(32'(pe.oe), 32'h0);
    chk(32'(pc.oe), 32'h0);
    $display("second reset done");
    stop_test();
  end

  initial
  begin
    repeat (1000) @(posedge i_clk);
    errors++;
    stop_test();
  end
endmodule

`default_nettype wire
